// ### pkg/bcss_pkg.sv
/*
 * Constants, field layouts and carrier types for the bridge configuration
 * space slice. Assumes a 50 MHz core clock and dword-aligned config accesses.
 */
package bcss_pkg;

	// ==========================================================================
	// Register offsets (byte addresses of dwords)
	localparam logic [11:0] OFF_ID_WORD       = 12'h000;
	localparam logic [11:0] OFF_COMMAND       = 12'h004;
	localparam logic [11:0] OFF_PORT_CAP_ONE  = 12'h154;
	localparam logic [11:0] OFF_PORT_CAP_TWO  = 12'h158;
	localparam logic [11:0] OFF_PORT_CTL_STS  = 12'h15c;
	localparam logic [11:0] OFF_CH0_RES_CAP   = 12'h160;
	localparam logic [11:0] OFF_CH0_RES_CTL   = 12'h164;
	localparam logic [11:0] OFF_CH0_RES_STS   = 12'h168;
	localparam logic [11:0] OFF_EXT_PIN_CTL   = 12'h300;
	localparam logic [11:0] OFF_SPARE_PIN_CTL = 12'h304;
	localparam logic [11:0] OFF_RETRY_TIMERS  = 12'h310;

	// ==========================================================================
	// Field positions
	localparam int EXT_CLR_LSB   = 0;
	localparam int EXT_SET_LSB   = 3;
	localparam int EXT_OECLR_LSB = 6;
	localparam int EXT_OESET_LSB = 9;
	localparam int EXT_IN_LSB    = 12;
	localparam int SPR_CLR_LSB   = 0;
	localparam int SPR_SET_LSB   = 4;
	localparam int SPR_OECLR_LSB = 8;
	localparam int SPR_OESET_LSB = 12;
	localparam int SPR_IN_LSB    = 16;
	localparam int REPLAY_EN_BIT = 12;
	localparam int ACK_LSB       = 16;
	localparam int CH0_EN_BIT    = 31;

	localparam int CMD_IO_EN     = 0;
	localparam int CMD_MEM_EN    = 1;
	localparam int CMD_MASTER_EN = 2;
	localparam int CMD_PARITY_EN = 6;
	localparam int CMD_SERR_EN   = 8;
	localparam int CMD_INT_DIS   = 10;

	// ==========================================================================
	// Reset values and fixed fields
	localparam logic [15:0] CMD_WRITABLE     = 16'h0547;
	localparam logic [15:0] CMD_RESET        = 16'h0000;
	localparam logic [6:0]  CH0_MAP_RESET    = 7'h7f;
	localparam logic [11:0] REPLAY_RESET     = 12'h000;
	localparam logic [13:0] ACK_RESET        = 14'h0000;
	localparam logic [2:0]  EXT_RESET        = 3'h0;
	localparam logic [3:0]  SPR_RESET        = 4'h0;
	// Identity codes: arbitrary neutral values
	localparam logic [15:0] VENDOR_CODE_DEF  = 16'h1234;
	localparam logic [15:0] PART_CODE_DEF    = 16'h5678;

	// ==========================================================================
	// Carriers
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [11:0] addr;
		logic [31:0] wdata;
	} bcss_cfg_req_t;

	typedef struct packed {
		logic [2:0] ext;
		logic [3:0] spare;
	} bcss_pins_t;

	typedef struct packed {
		logic ioEnable;
		logic memEnable;
		logic masterEnable;
		logic parityRespEnable;
		logic serrEnable;
		logic intDisable;
	} bcss_cmd_t;

endpackage : bcss_pkg

// ### design/bcss_config_slice.sv
/*
 * Configuration register slice of the bridge: channel-zero control word,
 * set/clear GPIO and spare output control, link retry timers,
 * identity word and primary command register with its gating effects.
 * Assumes the configuration decoder presents one-cycle rd/wr strobes on
 * core_clk and that pin inputs come from outside the clock domain.
 */
`timescale 1ns/1ns

// Operation
// (RQ1) Ones in extended control bits 2:0 clear matching extended outputs.
// (RQ2) Ones in extended control bits 5:3 set matching extended outputs.
// (RQ3) Ones in extended bits 8:6 disable matching extended drivers.
// (RQ4) Ones in extended bits 11:9 enable matching extended drivers.
// (RQ5) Ones in spare bits 3:0 clear matching spare outputs.
// (RQ6) Ones in spare bits 7:4 set matching spare outputs.
// (RQ7) Ones in spare bits 11:8 disable matching spare drivers.
// (RQ8) Ones in spare bits 15:12 enable matching spare drivers.
// (RQ9) Spare input levels read back in bits 19:16.
// (RQ10) Writable 12-bit replay value and enable bit, reset zero.
// (RQ11) Writable 14-bit ack latency value; its enable reads zero.
// (RQ12) Traffic-class map bit0 fixed one, bits 7:1 writable reset 7Fh, enable one.
// (RQ13) I/O space enable gates primary I/O transaction response.
// (RQ14) Memory space enable gates primary memory read acceptance.
// (RQ15) Master enable gates primary initiation and secondary response.
// (RQ16) Reverse bridge with PCI-X primary may issue split completions regardless.
// (RQ17) Special cycle enable reads zero; never respond to special cycles.
// (RQ18) Write-and-invalidate enable reads zero; only forwarded ones pass. The code also blocks forwarded ones for a reverse bridge with PCI-X primary.
// (RQ19) Parity response enable gates the master data parity error flag.
// (RQ20) System error enable gates error messages forward, SERR drive reverse.
// (RQ21) Interrupt disable blocks and releases INTx.
// (RQ22) Non-transparent mode returns fixed vendor and part codes.
// (RQ23) Pins drive only while output enable set, else float.
module bcss_config_slice
	import bcss_pkg::*;
#(
	parameter logic [15:0] VENDOR_CODE = VENDOR_CODE_DEF,
	parameter logic [15:0] PART_CODE   = PART_CODE_DEF
) (
	input  wire logic          core_clk,
	input  wire logic          srst,
	input  wire bcss_cfg_req_t cfgReq,
	output logic [31:0]        cfgRdata,
	output logic               cfgRvalid,
	input  wire logic          nonTransparent,
	input  wire logic          reverseMode,
	input  wire logic          primaryPcix,
	input  wire bcss_pins_t    pinIn,
	output bcss_pins_t         pinOut,
	output bcss_pins_t         pinOe,
	input  wire logic          priIoReq,
	input  wire logic          priMemRdReq,
	input  wire logic          priSpecialReq,
	input  wire logic          secMemIoReq,
	input  wire logic          fwdMasterReq,
	input  wire logic          splitCplReq,
	input  wire logic          fwdMwiReq,
	input  wire logic          parityEvent,
	input  wire logic          parityFlagClr,
	input  wire logic          errEvent,
	input  wire logic          intxReq,
	output logic               priIoAccept,
	output logic               priMemRdAccept,
	output logic               priSpecialAccept,
	output logic               secMemIoAccept,
	output logic               fwdMasterGrant,
	output logic               mwiIssue,
	output logic               parityErrFlag,
	output logic               errMsgSend,
	output logic               serrDrive,
	output logic               intxAssert,
	output bcss_cmd_t          cmdState
);

	// ==========================================================================
	// Input synchronisers
	bcss_pins_t pinMeta;
	bcss_pins_t pinSync;

	always_ff @(posedge core_clk) begin
		pinMeta <= pinIn;
		pinSync <= pinMeta;
	end

	// ==========================================================================
	// Write decode
	function automatic logic hit(input bcss_cfg_req_t r, input logic [11:0] off);
		hit = r.wr && (r.addr == off);
	endfunction : hit

	logic wrExt;
	logic wrSpare;
	logic wrTimers;
	logic wrCh0;
	logic wrCmd;

	assign wrExt    = hit(cfgReq, OFF_EXT_PIN_CTL);
	assign wrSpare  = hit(cfgReq, OFF_SPARE_PIN_CTL);
	assign wrTimers = hit(cfgReq, OFF_RETRY_TIMERS);
	assign wrCh0    = hit(cfgReq, OFF_CH0_RES_CTL);
	assign wrCmd    = hit(cfgReq, OFF_COMMAND);

	// ==========================================================================
	// Extended GPIO set/clear
	logic [2:0] extOut;
	logic [2:0] extOe;
	logic [2:0] next_extOut;
	logic [2:0] next_extOe;

	always_comb begin
		next_extOut = extOut;
		next_extOe  = extOe;
		if (wrExt) begin
			// Set after clear: a word holding both leaves the pin high
			next_extOut = next_extOut & ~cfgReq.wdata[EXT_CLR_LSB +: 3]; // RQ1
			next_extOut = next_extOut | cfgReq.wdata[EXT_SET_LSB +: 3]; // RQ2
			next_extOe  = next_extOe & ~cfgReq.wdata[EXT_OECLR_LSB +: 3]; // RQ3
			next_extOe  = next_extOe | cfgReq.wdata[EXT_OESET_LSB +: 3]; // RQ4
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			extOut <= EXT_RESET;
			extOe  <= EXT_RESET;
		end else begin
			extOut <= next_extOut;
			extOe  <= next_extOe;
		end
	end

	// ==========================================================================
	// Spare outputs set/clear
	logic [3:0] sprOut;
	logic [3:0] sprOe;
	logic [3:0] next_sprOut;
	logic [3:0] next_sprOe;

	always_comb begin
		next_sprOut = sprOut;
		next_sprOe  = sprOe;
		if (wrSpare) begin
			next_sprOut = next_sprOut & ~cfgReq.wdata[SPR_CLR_LSB +: 4]; // RQ5
			next_sprOut = next_sprOut | cfgReq.wdata[SPR_SET_LSB +: 4]; // RQ6
			next_sprOe  = next_sprOe & ~cfgReq.wdata[SPR_OECLR_LSB +: 4]; // RQ7
			next_sprOe  = next_sprOe | cfgReq.wdata[SPR_OESET_LSB +: 4]; // RQ8
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			sprOut <= SPR_RESET;
			sprOe  <= SPR_RESET;
		end else begin
			sprOut <= next_sprOut;
			sprOe  <= next_sprOe;
		end
	end

	// Driven value is the stored one; the enable alone decides whether it floats
	always_comb begin
		pinOut.ext   = extOut; // RQ23
		pinOut.spare = sprOut;
		pinOe.ext    = extOe; // RQ23
		pinOe.spare  = sprOe;
	end

	// ==========================================================================
	// Retry timers and channel-zero map
	logic [11:0] replayVal;
	logic        replayEn;
	logic [13:0] ackVal;
	logic [6:0]  ch0Map;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			replayVal <= REPLAY_RESET;
			replayEn  <= 1'b0;
			ackVal    <= ACK_RESET;
		end else if (wrTimers) begin
			replayVal <= cfgReq.wdata[11:0]; // RQ10
			replayEn  <= cfgReq.wdata[REPLAY_EN_BIT]; // RQ10
			ackVal    <= cfgReq.wdata[ACK_LSB +: 14]; // RQ11
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ch0Map <= CH0_MAP_RESET;
		end else if (wrCh0) begin
			ch0Map <= cfgReq.wdata[7:1]; // RQ12
		end
	end

	// ==========================================================================
	// Primary command register
	logic [15:0] cmdReg;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			cmdReg <= CMD_RESET;
		end else if (wrCmd) begin
			// Special cycle and write-and-invalidate bits never store
			cmdReg <= cfgReq.wdata[15:0] & CMD_WRITABLE; // RQ17 RQ18
		end
	end

	always_comb begin
		cmdState.ioEnable         = cmdReg[CMD_IO_EN];
		cmdState.memEnable        = cmdReg[CMD_MEM_EN];
		cmdState.masterEnable     = cmdReg[CMD_MASTER_EN];
		cmdState.parityRespEnable = cmdReg[CMD_PARITY_EN];
		cmdState.serrEnable       = cmdReg[CMD_SERR_EN];
		cmdState.intDisable       = cmdReg[CMD_INT_DIS];
	end

	// ==========================================================================
	// Transaction gating
	assign priIoAccept      = priIoReq & cmdReg[CMD_IO_EN]; // RQ13
	assign priMemRdAccept   = priMemRdReq & cmdReg[CMD_MEM_EN]; // RQ14
	assign secMemIoAccept   = secMemIoReq & cmdReg[CMD_MASTER_EN]; // RQ15
	assign priSpecialAccept = 1'b0; // RQ17
	// Split completions bypass master enable only for reverse PCI-X primary
	assign fwdMasterGrant   = (fwdMasterReq & cmdReg[CMD_MASTER_EN]) // RQ15
		| (splitCplReq & reverseMode & primaryPcix); // RQ16
	// Only a forwarded write-and-invalidate goes out, and not with reverse PCI-X primary; never one of our own
	assign mwiIssue         = fwdMwiReq & ~(reverseMode & primaryPcix); // RQ18
	assign errMsgSend       = errEvent & cmdReg[CMD_SERR_EN] & ~reverseMode; // RQ20
	assign serrDrive        = errEvent & cmdReg[CMD_SERR_EN] & reverseMode; // RQ20
	assign intxAssert       = intxReq & ~cmdReg[CMD_INT_DIS]; // RQ21

	// Sticky flag; a new event beats a same-cycle clear
	always_ff @(posedge core_clk) begin
		if (srst) begin
			parityErrFlag <= 1'b0;
		end else if (parityEvent && cmdReg[CMD_PARITY_EN]) begin
			parityErrFlag <= 1'b1; // RQ19
		end else if (parityFlagClr) begin
			parityErrFlag <= 1'b0;
		end
	end

	// ==========================================================================
	// Read mux
	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (cfgReq.addr)
			OFF_ID_WORD: begin
				if (nonTransparent) begin
					next_rdata = {PART_CODE, VENDOR_CODE}; // RQ22
				end
			end
			OFF_COMMAND: begin
				next_rdata = {16'h0000, cmdReg};
			end
			OFF_CH0_RES_CTL: begin
				next_rdata = {1'b1, 23'h000000, ch0Map, 1'b1}; // RQ12
			end
			OFF_EXT_PIN_CTL: begin
				next_rdata = {17'h00000, pinSync.ext, extOe, extOe, extOut, extOut};
			end
			OFF_SPARE_PIN_CTL: begin
				next_rdata = {12'h000, pinSync.spare, sprOe, sprOe, sprOut, sprOut}; // RQ9
			end
			OFF_RETRY_TIMERS: begin
				next_rdata = {2'b00, ackVal, 3'b000, replayEn, replayVal}; // RQ10 RQ11
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			cfgRdata  <= 32'h0000_0000;
			cfgRvalid <= 1'b0;
		end else begin
			cfgRvalid <= cfgReq.rd;
			if (cfgReq.rd) begin
				cfgRdata <= next_rdata;
			end
		end
	end

	// ==========================================================================
	// Checks
	chk_ext_clear: assert property (@(posedge core_clk) disable iff (srst) // RQ1
		(wrExt && cfgReq.wdata[0] && !cfgReq.wdata[3]) |=> !pinOut.ext[0])
		else $error("extended output not cleared");
	chk_ext_set: assert property (@(posedge core_clk) disable iff (srst) // RQ2
		(wrExt && cfgReq.wdata[4]) |=> pinOut.ext[1])
		else $error("extended output not set");
	chk_ext_oe: assert property (@(posedge core_clk) disable iff (srst) // RQ4
		(wrExt && cfgReq.wdata[9]) |=> pinOe.ext[0])
		else $error("extended enable not set");
	chk_spare_oeclr: assert property (@(posedge core_clk) disable iff (srst) // RQ7
		(wrSpare && cfgReq.wdata[8] && !cfgReq.wdata[12]) |=> !pinOe.spare[0])
		else $error("spare enable not cleared");
	chk_spare_hold: assert property (@(posedge core_clk) disable iff (srst) // RQ5
		!wrSpare |=> $stable(pinOut.spare))
		else $error("spare output moved without write");
	chk_timer_read: assert property (@(posedge core_clk) disable iff (srst) // RQ11
		(cfgReq.rd && cfgReq.addr == OFF_RETRY_TIMERS) |=> !cfgRdata[30] && !cfgRdata[31])
		else $error("ack enable read nonzero");
	chk_map_read: assert property (@(posedge core_clk) disable iff (srst) // RQ12
		(cfgReq.rd && cfgReq.addr == OFF_CH0_RES_CTL) |=> cfgRdata[0] && cfgRdata[CH0_EN_BIT])
		else $error("channel map fixed bits wrong");
	chk_io_gate: assert property (@(posedge core_clk) disable iff (srst) // RQ13
		(wrCmd && !cfgReq.wdata[0]) |=> !priIoAccept)
		else $error("I/O accepted while disabled");
	chk_cmd_ro: assert property (@(posedge core_clk) disable iff (srst) // RQ17
		wrCmd |=> !cmdReg[3] && !cmdReg[4])
		else $error("read-only command bits stored");
	chk_parity_gate: assert property (@(posedge core_clk) disable iff (srst) // RQ19
		(!parityErrFlag && !cmdReg[CMD_PARITY_EN]) |=> !parityErrFlag)
		else $error("parity flag set while disabled");
	chk_int_dis: assert property (@(posedge core_clk) disable iff (srst) // RQ21
		cmdReg[CMD_INT_DIS] |-> !intxAssert)
		else $error("INTx while disabled");
	chk_ext_oeclr: assert property (@(posedge core_clk) disable iff (srst) // RQ3
		(wrExt && cfgReq.wdata[7] && !cfgReq.wdata[10]) |=> !pinOe.ext[1])
		else $error("extended enable not cleared");
	chk_ext_keep: assert property (@(posedge core_clk) disable iff (srst) // RQ1
		(wrExt && !cfgReq.wdata[2] && !cfgReq.wdata[5]) |=> $stable(pinOut.ext[2]))
		else $error("extended output moved on zero bits");
	chk_spare_clear: assert property (@(posedge core_clk) disable iff (srst) // RQ5
		(wrSpare && cfgReq.wdata[1] && !cfgReq.wdata[5]) |=> !pinOut.spare[1])
		else $error("spare output not cleared");
	chk_spare_set: assert property (@(posedge core_clk) disable iff (srst) // RQ6
		(wrSpare && cfgReq.wdata[6]) |=> pinOut.spare[2])
		else $error("spare output not set");
	chk_spare_oeset: assert property (@(posedge core_clk) disable iff (srst) // RQ8
		(wrSpare && cfgReq.wdata[15]) |=> pinOe.spare[3])
		else $error("spare enable not set");

	// ==========================================================================
	// Readback, storage and gating checks
	chk_spare_input: assert property (@(posedge core_clk) disable iff (srst) // RQ9
		(cfgReq.rd && cfgReq.addr == OFF_SPARE_PIN_CTL) |=> cfgRdata[SPR_IN_LSB +: 4] == $past(pinSync.spare))
		else $error("spare input levels not returned");
	chk_replay_write: assert property (@(posedge core_clk) disable iff (srst) // RQ10
		wrTimers |=> replayVal == $past(cfgReq.wdata[11:0]) && replayEn == $past(cfgReq.wdata[12]))
		else $error("replay timer not stored");
	chk_ack_write: assert property (@(posedge core_clk) disable iff (srst) // RQ11
		wrTimers |=> ackVal == $past(cfgReq.wdata[29:16]))
		else $error("ack latency value not stored");
	chk_map_write: assert property (@(posedge core_clk) disable iff (srst) // RQ12
		wrCh0 |=> ch0Map == $past(cfgReq.wdata[7:1]))
		else $error("channel map not stored");
	chk_mem_gate: assert property (@(posedge core_clk) disable iff (srst) // RQ14
		!cmdReg[CMD_MEM_EN] |-> !priMemRdAccept)
		else $error("memory read accepted while disabled");
	chk_sec_gate: assert property (@(posedge core_clk) disable iff (srst) // RQ15
		!cmdReg[CMD_MASTER_EN] |-> !secMemIoAccept)
		else $error("secondary access accepted while master disabled");
	chk_fwd_gate: assert property (@(posedge core_clk) disable iff (srst) // RQ15
		(!cmdReg[CMD_MASTER_EN] && !(reverseMode && primaryPcix)) |-> !fwdMasterGrant)
		else $error("primary initiation while master disabled");
	chk_split_pass: assert property (@(posedge core_clk) disable iff (srst) // RQ16
		(splitCplReq && reverseMode && primaryPcix) |-> fwdMasterGrant)
		else $error("split completion held back");
	chk_special_never: assert property (@(posedge core_clk) disable iff (srst) // RQ17
		priSpecialReq |-> !priSpecialAccept)
		else $error("special cycle accepted");
	chk_cmd_read: assert property (@(posedge core_clk) disable iff (srst) // RQ18
		(cfgReq.rd && cfgReq.addr == OFF_COMMAND) |=> !cfgRdata[3] && !cfgRdata[4])
		else $error("read-only command bits read nonzero");
	chk_err_gate: assert property (@(posedge core_clk) disable iff (srst) // RQ20
		!cmdReg[CMD_SERR_EN] |-> !errMsgSend && !serrDrive)
		else $error("error reported while disabled");
	chk_err_mode: assert property (@(posedge core_clk) disable iff (srst) // RQ20
		(errEvent && cmdReg[CMD_SERR_EN]) |-> (reverseMode ? serrDrive : errMsgSend))
		else $error("error report on wrong path");
	chk_id_word: assert property (@(posedge core_clk) disable iff (srst) // RQ22
		(cfgReq.rd && cfgReq.addr == OFF_ID_WORD && nonTransparent) |=> cfgRdata == {PART_CODE, VENDOR_CODE})
		else $error("identity word wrong");
	chk_int_pass: assert property (@(posedge core_clk) disable iff (srst) // RQ21
		(intxReq && !cmdReg[CMD_INT_DIS]) |-> intxAssert)
		else $error("INTx blocked while enabled");

endmodule : bcss_config_slice

// ### testbench/bcss_host_model.sv
/*
 * Host-side model of the configuration requester: single dword reads and writes.
 * Assumes the slice takes a strobe on the rising edge and answers a read on that same edge.
 */
`timescale 1ns/1ns
module bcss_host_model
	import bcss_pkg::*;
(
	input  wire logic        core_clk,
	output bcss_cfg_req_t    cfgReq,
	input  wire logic [31:0] cfgRdata,
	input  wire logic        cfgRvalid
);
	initial cfgReq = '0;

	// ==========================================================================
	// Accesses
	// Idle address and data show the inverse, so nothing leans on stale values
	task automatic cfgWrite(input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		cfgReq <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge core_clk);
		cfgReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask : cfgWrite

	task automatic cfgRead(input logic [11:0] a, output logic [31:0] d);
		@(posedge core_clk);
		cfgReq <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
		@(posedge core_clk);
		cfgReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 32'hffffffff};
		#1;
		// Valid stands one cycle only
		d = (cfgRvalid === 1'b1) ? cfgRdata : 'x;
	endtask : cfgRead
endmodule : bcss_host_model

// ### testbench/tb_bcss_config_slice.sv
/*
 * Self-checking bench for the configuration slice: register map, pin control,
 * timers, command gating. Assumes the host model in bcss_host_model.sv.
 */
`timescale 1ns/1ns
module tb_bcss_config_slice;
	import bcss_pkg::*;

	// ==========================================================================
	// Signals
	logic          core_clk = 1'b0;
	logic          srst     = 1'b1;
	bcss_cfg_req_t cfgReq;
	logic [31:0]   cfgRdata;
	logic          cfgRvalid;
	logic          nonTransparent = 1'b0;
	logic          reverseMode    = 1'b0;
	logic          primaryPcix    = 1'b0;
	bcss_pins_t    pinIn          = '0;
	bcss_pins_t    pinOut;
	bcss_pins_t    pinOe;
	logic [10:0]   ev             = '0;
	wire [8:0]     acc;
	logic          parityErrFlag;
	bcss_cmd_t     cmdState;
	int            seed           = 72;
	int            nMismatch      = 0;
	int            checksDone     = 0;

	always #10 core_clk = ~core_clk;

	bcss_host_model u_bcss_host_model (
		.core_clk  (core_clk),
		.cfgReq    (cfgReq),
		.cfgRdata  (cfgRdata),
		.cfgRvalid (cfgRvalid)
	);

	bcss_config_slice u_bcss_config_slice (
		.core_clk (core_clk), .srst (srst), .cfgReq (cfgReq), .cfgRdata (cfgRdata), .cfgRvalid (cfgRvalid),
		.nonTransparent (nonTransparent), .reverseMode (reverseMode), .primaryPcix (primaryPcix),
		.pinIn (pinIn), .pinOut (pinOut), .pinOe (pinOe),
		.priIoReq (ev[0]), .priMemRdReq (ev[1]), .priSpecialReq (ev[2]), .secMemIoReq (ev[3]),
		.fwdMasterReq (ev[4]), .splitCplReq (ev[5]), .fwdMwiReq (ev[6]), .parityEvent (ev[7]),
		.parityFlagClr (ev[8]), .errEvent (ev[9]), .intxReq (ev[10]),
		.priIoAccept (acc[0]), .priMemRdAccept (acc[1]), .priSpecialAccept (acc[2]),
		.secMemIoAccept (acc[3]), .fwdMasterGrant (acc[4]), .mwiIssue (acc[5]), .errMsgSend (acc[6]),
		.serrDrive (acc[7]), .intxAssert (acc[8]), .parityErrFlag (parityErrFlag), .cmdState (cmdState)
	);

	// ==========================================================================
	// Expectations and reporting
	function automatic logic [8:0] expAcc(logic [10:0] e, logic [15:0] c, logic rv, logic px);
		logic rp = rv & px;
		return {e[10] & ~c[10], e[9] & c[8] & rv, e[9] & c[8] & ~rv, e[6] & ~rp,
			e[4] & c[2] | e[5] & rp, e[3] & c[2], 1'b0, e[1] & c[1], e[0] & c[0]};
	endfunction : expAcc

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			nMismatch++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", checksDone, nMismatch);
		if (nMismatch == 0 && checksDone > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	// ==========================================================================
	// Watchdog, about fifteen times the expected run
	initial begin
		#400000;
		nMismatch++;
		report_and_stop();
	end

	// ==========================================================================
	// Main sequence
	initial begin
		logic [11:0] addrs [12];
		logic [31:0] d;
		logic [31:0] w;
		logic [15:0] c;
		logic [2:0]  eo;
		logic [2:0]  ee;
		logic [3:0]  so;
		logic [3:0]  se;
		logic        expFlag;
		addrs = '{12'h000, 12'h004, 12'h154, 12'h158, 12'h15c, 12'h160, 12'h164, 12'h168,
			12'h300, 12'h304, 12'h308, 12'h310};
		for (int r = 0; r < 2; r++) begin
			// Second pass repeats the map after a mid-run reset
			@(posedge core_clk) srst <= 1'b1;
			// Identity word must read zero in the map pass after reset
			nonTransparent <= 1'b0;
			repeat (6) @(posedge core_clk);
			srst <= 1'b0;
			{eo, ee, so, se, expFlag} = '0;
			foreach (addrs[k]) begin
				u_bcss_host_model.cfgRead(addrs[k], d);
				check(d, (addrs[k] == 12'h164) ? 32'h800000ff : {12'h0, pinIn.spare & {4{addrs[k] == 12'h304}},
					1'b0, pinIn.ext & {3{addrs[k] == 12'h300}}, 12'h0});
			end
			check({31'h0, parityErrFlag}, 32'h0);
			check({18'h0, pinOut, pinOe}, 32'h0);
			if (r == 1)
				report_and_stop();
			for (int i = 0; i < 40; i++) begin
				w = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : $random(seed);
				@(posedge core_clk) pinIn <= 7'($random(seed));
				u_bcss_host_model.cfgWrite(OFF_EXT_PIN_CTL, w);
				u_bcss_host_model.cfgWrite(OFF_SPARE_PIN_CTL, w);
				eo = (eo & ~w[2:0]) | w[5:3];
				ee = (ee & ~w[8:6]) | w[11:9];
				so = (so & ~w[3:0]) | w[7:4];
				se = (se & ~w[11:8]) | w[15:12];
				u_bcss_host_model.cfgRead(OFF_EXT_PIN_CTL, d);
				check(d, {17'h0, pinIn.ext, ee, ee, eo, eo});
				u_bcss_host_model.cfgRead(OFF_SPARE_PIN_CTL, d);
				check(d, {12'h0, pinIn.spare, se, se, so, so});
				check({18'h0, pinOut, pinOe}, {18'h0, eo, so, ee, se});
				u_bcss_host_model.cfgWrite(OFF_RETRY_TIMERS, w);
				u_bcss_host_model.cfgRead(OFF_RETRY_TIMERS, d);
				check(d, w & 32'h3fff1fff);
				u_bcss_host_model.cfgWrite(OFF_CH0_RES_CTL, w);
				u_bcss_host_model.cfgRead(OFF_CH0_RES_CTL, d);
				check(d, {1'b1, 23'h0, w[7:1], 1'b1});
				@(posedge core_clk) nonTransparent <= w[20];
				u_bcss_host_model.cfgRead(OFF_ID_WORD, d);
				check(d, w[20] ? {PART_CODE_DEF, VENDOR_CODE_DEF} : 32'h0);
				c = w[31:16];
				u_bcss_host_model.cfgWrite(OFF_COMMAND, {16'h0, c});
				u_bcss_host_model.cfgRead(OFF_COMMAND, d);
				check(d, {16'h0, c & CMD_WRITABLE});
				check({26'h0, cmdState}, {26'h0, c[0], c[1], c[2], c[6], c[8], c[10]});
				for (int j = 0; j < 6; j++) begin
					@(posedge core_clk);
					ev <= 11'($random(seed));
					{reverseMode, primaryPcix} <= 2'($random(seed));
					#1;
					check({23'h0, acc}, {23'h0, expAcc(ev, c, reverseMode, primaryPcix)});
					check({31'h0, parityErrFlag}, {31'h0, expFlag});
					expFlag = (ev[7] & c[6]) | (~ev[8] & expFlag);
				end
				@(posedge core_clk) ev <= '0;
			end
		end
	end
endmodule : tb_bcss_config_slice
